// [pkg/zsc_pkg.sv]
// Constants for the zero speed clamp velocity mode block
package zsc_pkg;
   // ==========================================================
   // Register map, byte addresses
   localparam logic [7:0] OFF_MODE      = 8'h00;
   localparam logic [7:0] OFF_CLAMP_SRC = 8'h04;
   localparam logic [7:0] OFF_ZERO_THR  = 8'h08;
   localparam logic [7:0] OFF_DWELL     = 8'h0c;
   localparam logic [7:0] OFF_ACCEL     = 8'h10;
   localparam logic [7:0] OFF_CLAMP_FN  = 8'h14;
   localparam logic [7:0] OFF_SPEED_CMD = 8'h18;
   localparam logic [7:0] OFF_STATUS    = 8'h1c;
   localparam logic [7:0] OFF_LOCK_POS  = 8'h20;
   localparam logic [7:0] OFF_SPEED_REF = 8'h24;
   // ==========================================================
   // Status fields
   localparam int ST_LOCK_BIT  = 0;
   localparam int ST_REQ_BIT   = 1;
   localparam int ST_CZERO_BIT = 2;
   localparam int ST_ABELOW_BIT = 3;
   // ==========================================================
   // Codes and reset values; speeds in 0.1 rps
   localparam logic [7:0]  MODE_VELOCITY  = 8'h0f;
   localparam logic [7:0]  MODE_MODBUS    = 8'h15;
   localparam logic [7:0]  FN_CLOSED_ACT  = 8'h15;
   localparam logic [7:0]  FN_OPEN_ACT    = 8'h16;
   localparam logic [7:0]  FN_NONE        = 8'h00;
   localparam logic        SRC_INPUT      = 1'b0;
   localparam logic        SRC_DWELL      = 1'b1;
   localparam logic [4:0]  THR_MIN        = 5'h01;
   localparam logic [4:0]  THR_MAX        = 5'h14;
   localparam logic [4:0]  THR_RESET      = 5'h05;
   localparam logic [14:0] DWELL_MAX      = 15'h7530;
   localparam logic [14:0] DWELL_RESET    = 15'h000a;
   localparam logic [15:0] ACCEL_RESET    = 16'h000a;
   // ==========================================================
   // Timing
   localparam int CLK_MHZ  = 250;
   localparam int MS_IN_US = 1000;
   localparam int MS_CYCLES = CLK_MHZ * MS_IN_US;
endpackage

// [verilog/zsc_ms_tick.sv]
// Millisecond enable pulse divider
`timescale 1ns/1ps
module zsc_ms_tick #(
   parameter int DIV = 250000
) (
   input  wire logic i_clk,
   input  wire logic i_resetn,
   output logic      o_tick
);
   localparam int CW = $clog2(DIV);

   logic [CW-1:0] cnt_r;

   if (DIV < 2) begin : g_chk
      $error("zsc_ms_tick: DIV must be at least 2");
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt_r  <= '0;
         o_tick <= 1'b0;
      end else if (cnt_r == CW'(DIV - 1)) begin
         cnt_r  <= '0;
         o_tick <= 1'b1;
      end else begin
         cnt_r  <= cnt_r + 1'b1;
         o_tick <= 1'b0;
      end
   end
endmodule

// [verilog/zsc_clamp.sv]
// Zero speed clamp and speed ramp for velocity control mode
`timescale 1ns/1ps
module zsc_clamp #(
   parameter int MS_CYCLES = zsc_pkg::MS_CYCLES
) (
   input  wire logic               i_clk,
   input  wire logic               i_resetn,
   input  wire logic [7:0]         i_addr,
   input  wire logic [31:0]        i_wdata,
   input  wire logic               i_wr,
   input  wire logic               i_rd,
   output logic [31:0]             o_rdata,
   input  wire logic               i_clamp_contact,
   input  wire logic signed [15:0] i_int_speed,
   input  wire logic signed [15:0] i_act_speed,
   input  wire logic signed [31:0] i_act_pos,
   output logic                    o_pos_lock,
   output logic signed [31:0]      o_lock_pos,
   output logic signed [31:0]      o_pos_err,
   output logic signed [15:0]      o_speed_ref
);
   typedef enum logic {ZSC_RUN, ZSC_LOCK} zsc_state_e;

   // Divider needs at least two cycles per tick
   if (MS_CYCLES < 2) begin : g_chk
      $error("zsc_clamp: MS_CYCLES must be at least 2");
   end

   // ==========================================================
   // Configuration registers
   logic [7:0]         mode_r;
   logic               src_r;
   logic [4:0]         thr_r;
   logic [14:0]        dwell_r;
   logic [15:0]        accel_r;
   logic [7:0]         fn_r;
   logic signed [15:0] mb_speed_r;

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         mode_r  <= zsc_pkg::MODE_VELOCITY;
         src_r   <= zsc_pkg::SRC_INPUT;
         thr_r   <= zsc_pkg::THR_RESET;
         dwell_r <= zsc_pkg::DWELL_RESET;
         accel_r <= zsc_pkg::ACCEL_RESET;
         fn_r    <= zsc_pkg::FN_NONE;
      end else if (i_wr) begin
         unique case (i_addr)
            zsc_pkg::OFF_MODE: mode_r <= i_wdata[7:0];
            zsc_pkg::OFF_CLAMP_SRC: begin
               if (i_wdata[31:1] == '0) src_r <= i_wdata[0];
            end
            zsc_pkg::OFF_ZERO_THR: begin
               if (i_wdata >= 32'(zsc_pkg::THR_MIN) && i_wdata <= 32'(zsc_pkg::THR_MAX))
                  thr_r <= i_wdata[4:0];
            end
            zsc_pkg::OFF_DWELL: begin
               if (i_wdata <= 32'(zsc_pkg::DWELL_MAX)) dwell_r <= i_wdata[14:0];
            end
            zsc_pkg::OFF_ACCEL:    accel_r <= i_wdata[15:0];
            zsc_pkg::OFF_CLAMP_FN: fn_r    <= i_wdata[7:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         mb_speed_r <= '0;
      end else if (i_wr && i_addr == zsc_pkg::OFF_SPEED_CMD &&
                   mode_r == zsc_pkg::MODE_MODBUS) begin
         mb_speed_r <= i_wdata[15:0];
      end
   end

   // ==========================================================
   // Clamp request input
   logic sync1_r;
   logic sync2_r;
   logic req;

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end else begin
         sync1_r <= i_clamp_contact;
         sync2_r <= sync1_r;
      end
   end

   always_comb begin
      if (fn_r == zsc_pkg::FN_CLOSED_ACT) req = sync2_r;
      else if (fn_r == zsc_pkg::FN_OPEN_ACT) req = !sync2_r;
      else req = 1'b0;
   end

   // ==========================================================
   // Zero speed decisions
   logic signed [15:0] cmd;
   logic [15:0]        cmd_mag;
   logic [15:0]        act_mag;
   logic               cmd_zero;
   logic               act_below;

   assign cmd     = (mode_r == zsc_pkg::MODE_MODBUS) ? mb_speed_r : i_int_speed;
   assign cmd_mag = cmd[15] ? 16'(-cmd) : cmd;
   assign act_mag = i_act_speed[15] ? 16'(-i_act_speed) : i_act_speed;
   // command at or below threshold counts as zero; actual speed must be strictly below
   assign cmd_zero  = cmd_mag <= 16'(thr_r);
   assign act_below = act_mag < 16'(thr_r);

   logic ms_tick;

   zsc_ms_tick #(
      .DIV (MS_CYCLES)
   ) u_tick (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .o_tick   (ms_tick)
   );

   // ==========================================================
   // Dwell timer
   logic [14:0] dwell_cnt_r;
   logic        dwell_cond;
   logic        dwell_done;

   assign dwell_cond = cmd_zero && act_below;
   assign dwell_done = dwell_cond && dwell_cnt_r >= dwell_r;

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         dwell_cnt_r <= '0;
      end else if (!dwell_cond) begin
         dwell_cnt_r <= '0;
      end else if (ms_tick && dwell_cnt_r < dwell_r) begin
         dwell_cnt_r <= dwell_cnt_r + 1'b1;
      end
   end

   // ==========================================================
   // Lock state machine
   zsc_state_e state_r;
   logic       lock_go;

   always_comb begin
      // source 1 never reads the request
      if (src_r == zsc_pkg::SRC_DWELL) lock_go = dwell_done;
      else lock_go = req && cmd_zero;
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_r <= ZSC_RUN;
      end else begin
         unique case (state_r)
            ZSC_RUN: begin
               if (lock_go) state_r <= ZSC_LOCK;
            end
            ZSC_LOCK: begin
               if (!cmd_zero) state_r <= ZSC_RUN;
               else if (src_r == zsc_pkg::SRC_INPUT && !req) state_r <= ZSC_RUN;
            end
         endcase
      end
   end

   assign o_pos_lock = state_r == ZSC_LOCK;

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_lock_pos <= '0;
      end else if (state_r == ZSC_RUN && lock_go) begin
         o_lock_pos <= i_act_pos;
      end
   end

   // displacement drives the position loop back
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_pos_err <= '0;
      end else if (o_pos_lock) begin
         o_pos_err <= o_lock_pos - i_act_pos;
      end else begin
         o_pos_err <= '0;
      end
   end

   // ==========================================================
   // Speed ramp, one step per millisecond
   logic signed [16:0] target;
   logic signed [16:0] diff;
   logic signed [16:0] step;

   assign target = cmd_zero ? 17'sd0 : 17'(cmd);
   assign diff   = target - 17'(o_speed_ref);
   assign step   = 17'(signed'({1'b0, accel_r}));

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_speed_ref <= '0;
      end else if (o_pos_lock) begin
         // Position loop owns the shaft while locked
         o_speed_ref <= '0;
      end else if (ms_tick) begin
         if (diff > step) o_speed_ref <= 16'(17'(o_speed_ref) + step);
         else if (diff < -step) o_speed_ref <= 16'(17'(o_speed_ref) - step);
         else o_speed_ref <= 16'(target);
      end
   end

   // ==========================================================
   // Read port, data one cycle after the strobe
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rdata <= '0;
      end else if (i_rd) begin
         unique case (i_addr)
            zsc_pkg::OFF_MODE:      o_rdata <= {24'h0, mode_r};
            zsc_pkg::OFF_CLAMP_SRC: o_rdata <= {31'h0, src_r};
            zsc_pkg::OFF_ZERO_THR:  o_rdata <= {27'h0, thr_r};
            zsc_pkg::OFF_DWELL:     o_rdata <= {17'h0, dwell_r};
            zsc_pkg::OFF_ACCEL:     o_rdata <= {16'h0, accel_r};
            zsc_pkg::OFF_CLAMP_FN:  o_rdata <= {24'h0, fn_r};
            zsc_pkg::OFF_SPEED_CMD: o_rdata <= {{16{mb_speed_r[15]}}, mb_speed_r};
            zsc_pkg::OFF_STATUS: begin
               o_rdata <= '0;
               o_rdata[zsc_pkg::ST_LOCK_BIT]   <= o_pos_lock;
               o_rdata[zsc_pkg::ST_REQ_BIT]    <= req;
               o_rdata[zsc_pkg::ST_CZERO_BIT]  <= cmd_zero;
               o_rdata[zsc_pkg::ST_ABELOW_BIT] <= act_below;
            end
            zsc_pkg::OFF_LOCK_POS:  o_rdata <= o_lock_pos;
            zsc_pkg::OFF_SPEED_REF: o_rdata <= {{16{o_speed_ref[15]}}, o_speed_ref};
            default:                o_rdata <= '0;
         endcase
      end else begin
         o_rdata <= '0;
      end
   end

   // ==========================================================
   // Checks
   // speed command gated by mode
   mb_gate_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (mode_r != zsc_pkg::MODE_MODBUS) |=> $stable(mb_speed_r))
      else $error("speed command changed outside mode 21");

   // source 0 lock needs request and zero
   src0_lock_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      $rose(o_pos_lock) && $past(src_r) == zsc_pkg::SRC_INPUT
         |-> $past(req) && $past(cmd_zero))
      else $error("source 0 lock without request and zero command");

   hold_err_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_pos_lock ##1 o_pos_lock |-> o_pos_err == $past(o_lock_pos - i_act_pos))
      else $error("locked displacement wrong");

   fn_closed_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      fn_r == zsc_pkg::FN_CLOSED_ACT && $past(fn_r, 2) == zsc_pkg::FN_CLOSED_ACT
         |-> req == $past(i_clamp_contact, 2))
      else $error("code 21 polarity wrong");

   fn_open_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      fn_r == zsc_pkg::FN_OPEN_ACT && $past(fn_r, 2) == zsc_pkg::FN_OPEN_ACT
         |-> req == !$past(i_clamp_contact, 2))
      else $error("code 22 polarity wrong");

   // source 1 enters on dwell alone
   src1_enter_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      !o_pos_lock && src_r == zsc_pkg::SRC_DWELL && dwell_done |=> o_pos_lock)
      else $error("source 1 did not lock after dwell");

   src1_only_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      $rose(o_pos_lock) && $past(src_r) == zsc_pkg::SRC_DWELL |-> $past(dwell_done))
      else $error("source 1 locked before dwell");

   release_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_pos_lock && !cmd_zero |=> !o_pos_lock)
      else $error("lock held with nonzero command");

   range_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      thr_r >= zsc_pkg::THR_MIN && thr_r <= zsc_pkg::THR_MAX
         && dwell_r <= zsc_pkg::DWELL_MAX)
      else $error("setting out of range");

   capture_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      $rose(o_pos_lock) |-> o_lock_pos == $past(i_act_pos))
      else $error("lock position not captured");

   restart_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      !dwell_cond |=> dwell_cnt_r == '0)
      else $error("dwell not restarted");

   src0_norq_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      src_r == zsc_pkg::SRC_INPUT && !req |=> !o_pos_lock)
      else $error("source 0 locked without request");

   lock_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_pos_lock ##1 o_pos_lock |-> $stable(o_lock_pos))
      else $error("lock position moved while locked");

   ramp_idle_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_pos_lock |=> o_speed_ref == '0)
      else $error("speed reference nonzero while locked");

   src_refuse_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_wr && i_addr == zsc_pkg::OFF_CLAMP_SRC && i_wdata[31:1] != '0 |=> $stable(src_r))
      else $error("out of range source value taken");

   lock_src0_c: cover property (@(posedge i_clk) disable iff (!i_resetn)
      $rose(o_pos_lock) && src_r == zsc_pkg::SRC_INPUT);
   lock_src1_c: cover property (@(posedge i_clk) disable iff (!i_resetn)
      $rose(o_pos_lock) && src_r == zsc_pkg::SRC_DWELL);
   unlock_c: cover property (@(posedge i_clk) disable iff (!i_resetn)
      $fell(o_pos_lock) ##[1:20] o_speed_ref != '0);
endmodule

// [verification/zsc_motor_model.sv]
// Motor model with speed feedback and an external push on the shaft
`timescale 1ns/1ps
module zsc_motor_model #(
   parameter int PUSH = 100
) (
   input  wire logic               i_clk,
   input  wire logic               i_resetn,
   input  wire logic signed [15:0] i_speed_ref,
   input  wire logic               i_push,
   output logic signed [15:0]      o_act_speed,
   output logic signed [31:0]      o_act_pos
);
   // ==========================================================
   // Shaft dynamics
   // Speed follows the reference one cycle late, so that the feedback lags
   // Push moves the shaft without any commanded speed
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_act_speed <= 16'sh0000;
         o_act_pos   <= 32'sh00001000;
      end else begin
         o_act_speed <= i_speed_ref;
         o_act_pos   <= o_act_pos + 32'(o_act_speed) + (i_push ? 32'(PUSH) : 32'sh0);
      end
   end
endmodule

// [verification/zsc_clamp_tb_top.sv]
// Self-checking testbench for the zero speed clamp block
`timescale 1ns/1ps
module zsc_clamp_tb_top;
   localparam int MSC = 8;
   logic               i_clk;
   logic               i_resetn;
   logic [7:0]         i_addr;
   logic [31:0]        i_wdata;
   logic               i_wr;
   logic               i_rd;
   logic [31:0]        o_rdata;
   logic               i_clamp_contact;
   logic signed [15:0] i_int_speed;
   logic signed [15:0] act_speed;
   logic signed [31:0] act_pos;
   logic               o_pos_lock;
   logic signed [31:0] o_lock_pos;
   logic signed [31:0] o_pos_err;
   logic signed [15:0] o_speed_ref;
   logic               push;
   logic [31:0]        d;
   logic [31:0]        lp;
   int                 mismatches;
   int                 n_tests;
   int                 cyc;
   int                 n;
   logic [7:0]         ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h30};
   logic [31:0]        re [8] = '{32'h0f, 32'h0, 32'h5, 32'ha, 32'ha, 32'h0, 32'h0, 32'h0};

   zsc_clamp #(.MS_CYCLES(MSC)) i_dut (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_clamp_contact(i_clamp_contact),
      .i_int_speed(i_int_speed), .i_act_speed(act_speed), .i_act_pos(act_pos),
      .o_pos_lock(o_pos_lock), .o_lock_pos(o_lock_pos), .o_pos_err(o_pos_err),
      .o_speed_ref(o_speed_ref));

   zsc_motor_model i_motor (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_speed_ref(o_speed_ref), .i_push(push),
      .o_act_speed(act_speed), .o_act_pos(act_pos));

   // ==========================================================
   // Clock, timeout and verdict
   initial i_clk = 1'b0;
   always #2 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         conclude();
      end
   end
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ==========================================================
   // Bus access and compare tasks
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge i_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= v;
      @(posedge i_clk);
      i_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge i_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd   <= 1'b0;
      #1 d = o_rdata;
   endtask
   task automatic chk32(input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   task automatic chk1(input logic exp, input logic got);
      chk32({31'h0, exp}, {31'h0, got});
   endtask
   task automatic set_in(input logic c, input logic signed [15:0] s);
      @(posedge i_clk);
      i_clamp_contact <= c;
      i_int_speed     <= s;
   endtask
   // Bounded wait so a lock that never comes cannot hang the run
   task automatic wait_lock(input logic exp, input int lim);
      int k;
      k = 0;
      while (o_pos_lock !== exp && k < lim) begin
         @(posedge i_clk);
         #1 k++;
      end
   endtask

   // ==========================================================
   // Test sequence
   initial begin
      {i_resetn, i_addr, i_wdata, i_wr, i_rd, i_clamp_contact, i_int_speed, push} = '0;
      repeat (10) @(posedge i_clk);
      i_resetn <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         rd(ra[i]);
         chk32(re[i], d);
      end
      wr(8'h04, 32'h2);
      rd(8'h04);
      chk32(32'h0, d);
      wr(8'h04, 32'h1);
      rd(8'h04);
      chk32(32'h1, d);
      wr(8'h04, 32'h0);
      wr(8'h08, 32'h0);
      rd(8'h08);
      chk32(32'h5, d);
      wr(8'h08, 32'h15);
      rd(8'h08);
      chk32(32'h5, d);
      wr(8'h08, 32'h14);
      rd(8'h08);
      chk32(32'h14, d);
      wr(8'h08, 32'h5);
      wr(8'h18, 32'h64);
      rd(8'h18);
      chk32(32'h0, d);
      wr(8'h00, 32'h15);
      wr(8'h18, 32'h64);
      rd(8'h18);
      chk32(32'h64, d);
      wr(8'h18, 32'h0);
      wr(8'h00, 32'h0f);
      $display("test registers done");
      wr(8'h14, 32'h15);
      repeat (20) @(posedge i_clk);
      #1 chk1(1'b0, o_pos_lock);
      set_in(1'b1, 16'sd0);
      wait_lock(1'b1, 10);
      chk1(1'b1, o_pos_lock);
      set_in(1'b1, 16'sd5);
      repeat (10) @(posedge i_clk);
      #1 chk1(1'b1, o_pos_lock);
      set_in(1'b1, 16'sd6);
      wait_lock(1'b0, 5);
      chk1(1'b0, o_pos_lock);
      set_in(1'b1, -16'sd5);
      wait_lock(1'b1, 5);
      chk1(1'b1, o_pos_lock);
      set_in(1'b0, 16'sd0);
      wait_lock(1'b0, 6);
      chk1(1'b0, o_pos_lock);
      wr(8'h14, 32'h16);
      wait_lock(1'b1, 10);
      chk1(1'b1, o_pos_lock);
      set_in(1'b1, 16'sd0);
      wait_lock(1'b0, 6);
      chk1(1'b0, o_pos_lock);
      set_in(1'b0, 16'sd0);
      wait_lock(1'b1, 10);
      chk1(1'b1, o_pos_lock);
      $display("test input clamp done");
      set_in(1'b0, 16'sd100);
      wait_lock(1'b0, 5);
      chk1(1'b0, o_pos_lock);
      repeat (20) @(posedge i_clk);
      #1 chk1(1'b1, o_speed_ref > 0 && o_speed_ref <= 16'sd30);
      repeat (120) @(posedge i_clk);
      #1 chk32(32'd100, 32'(o_speed_ref));
      $display("test ramp done");
      wr(8'h04, 32'h1);
      wr(8'h0c, 32'h2);
      set_in(1'b1, 16'sd0);
      n = 0;
      while (act_speed >= 16'sd5 && n < 300) begin
         @(posedge i_clk);
         #1 n++;
      end
      n = 0;
      while (o_pos_lock !== 1'b1 && n < 40) begin
         @(posedge i_clk);
         #1 n++;
      end
      chk1(1'b1, n >= MSC && n <= 4 * MSC);
      chk32(act_pos, o_lock_pos);
      lp = act_pos;
      @(posedge i_clk);
      push <= 1'b1;
      @(posedge i_clk);
      push <= 1'b0;
      repeat (3) @(posedge i_clk);
      #1 chk32(32'hffffff9c, o_pos_err);
      chk1(1'b1, o_pos_lock);
      // Status while locked: lock, zero command, slow shaft, no request
      rd(8'h1c);
      chk32(32'hd, d);
      rd(8'h20);
      chk32(lp, d);
      rd(8'h24);
      chk32(32'h0, d);
      set_in(1'b1, 16'sd20);
      wait_lock(1'b0, 5);
      chk1(1'b0, o_pos_lock);
      @(posedge i_clk);
      #1 chk32(32'h0, o_pos_err);
      $display("test dwell clamp done");
      conclude();
   end
endmodule
